// File: inc/ebc_pkg.sv
// Shared constants and types of the emulator break control block
package ebc_pkg;

	// ----------------------------------------------------------------
	// Region types of mapped memory
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		EBC_REG_NONE  = 3'h0,
		EBC_REG_ERAM  = 3'h1,
		EBC_REG_EROM  = 3'h2,
		EBC_REG_TRAM  = 3'h3,
		EBC_REG_TROM  = 3'h4,
		EBC_REG_GUARD = 3'h5
	} ebc_region_type;

	// ----------------------------------------------------------------
	// Break cause bit positions
	// ----------------------------------------------------------------
	localparam int EBC_CAUSE_W     = 11;
	localparam int EBC_C_ROM       = 0;
	localparam int EBC_C_GUARD     = 1;
	localparam int EBC_C_SWBP      = 2;
	localparam int EBC_C_UNEXP     = 3;
	localparam int EBC_C_COAX      = 4;
	localparam int EBC_C_CBTRIG    = 5;
	localparam int EBC_C_ANALYZER_TRIGGER_LINE_ONE     = 6;
	localparam int EBC_C_ANALYZER_TRIGGER_LINE_TWO     = 7;
	localparam int EBC_C_NOTREADY  = 8;
	localparam int EBC_C_EXECUTE   = 9;
	localparam int EBC_C_REQUEST   = 10;

	// ----------------------------------------------------------------
	// Sizes and reset values
	// ----------------------------------------------------------------
	localparam int EBC_ADDR_W      = 20;
	localparam int EBC_BP_ENTRIES  = 8;
	localparam int EBC_BP_IDX_W    = 3;
	localparam int EBC_SYNC_STAGES = 3;
	localparam logic [EBC_CAUSE_W-1:0] EBC_CAUSE_RESET = 11'h000;
	localparam logic [EBC_ADDR_W-1:0]  EBC_ADDR_RESET  = 20'h00000;

	// ----------------------------------------------------------------
	// Register operation status codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		EBC_RS_OK       = 2'h0,
		EBC_RS_NOBREAK  = 2'h1,
		EBC_RS_READONLY = 2'h2
	} ebc_reg_status_type;

endpackage : ebc_pkg

// File: design/ebc_sync.sv
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
`default_nettype none
module ebc_sync (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Pin and filtered level
	input  wire logic pin_in,
	output logic      level_out
);
	logic [ebc_pkg::EBC_SYNC_STAGES-1:0] stage_q;
	logic                                level_q;

	always_ff @(posedge clock) begin
		if (!rst_n)
			stage_q <= '0;
		else
			stage_q <= {stage_q[ebc_pkg::EBC_SYNC_STAGES-2:0], pin_in};
	end

	// First stage is only read by the second; change taken once stages 2 and 3 agree
	always_ff @(posedge clock) begin
		if (!rst_n)
			level_q <= 1'b0;
		else if (stage_q[1] == stage_q[2])
			level_q <= stage_q[2];
	end

	assign level_out = level_q;
endmodule : ebc_sync
`default_nettype wire

// File: design/ebc_bp_table.sv
// Software breakpoint address table with parallel lookup
`timescale 1ns/10ps
`default_nettype none
module ebc_bp_table (
	// Clock and reset
	input  wire logic                           clock,
	input  wire logic                           rst_n,
	// Table write port
	input  wire logic                           wr_en,
	input  wire logic [ebc_pkg::EBC_BP_IDX_W-1:0] wr_idx,
	input  wire logic [ebc_pkg::EBC_ADDR_W-1:0]   wr_addr,
	input  wire logic                           wr_valid,
	// Lookup
	input  wire logic [ebc_pkg::EBC_ADDR_W-1:0]   look_addr,
	output logic                                hit
);
	logic [ebc_pkg::EBC_ADDR_W-1:0]     addr_q  [ebc_pkg::EBC_BP_ENTRIES];
	logic [ebc_pkg::EBC_BP_ENTRIES-1:0] valid_q;
	logic [ebc_pkg::EBC_BP_ENTRIES-1:0] match;

	genvar g;
	generate
		for (g = 0; g < ebc_pkg::EBC_BP_ENTRIES; g++) begin : g_ent
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					addr_q[g]  <= ebc_pkg::EBC_ADDR_RESET;
					valid_q[g] <= 1'b0;
				end else if (wr_en && (wr_idx == ebc_pkg::EBC_BP_IDX_W'(g))) begin
					addr_q[g]  <= wr_addr;
					valid_q[g] <= wr_valid;
				end
			end
			assign match[g] = valid_q[g] && (addr_q[g] == look_addr);
		end
	endgenerate

	assign hit = |match;
endmodule : ebc_bp_table
`default_nettype wire

// File: design/ebc_break_ctrl.sv
// Break condition control of the emulation processor
`timescale 1ns/10ps
`default_nettype none
module ebc_break_ctrl (
	// Clock and reset
	input  wire logic                           clock,
	input  wire logic                           rst_n,
	// Break condition enables
	input  wire logic                           en_rom_break,
	input  wire logic                           en_soft_bp,
	input  wire logic                           en_coax_trig,
	input  wire logic                           en_cb_trig,
	input  wire logic                           en_trig_one,
	input  wire logic                           en_trig_two,
	input  wire logic                           coord_enable,
	input  wire logic                           restrict_real_time,
	input  wire logic [ebc_pkg::EBC_ADDR_W-1:0] run_address,
	// Processor access
	input  wire logic                           acc_valid,
	input  wire logic                           acc_write,
	input  wire ebc_pkg::ebc_region_type        acc_region,
	input  wire logic                           bp_exec,
	input  wire logic [ebc_pkg::EBC_ADDR_W-1:0] acc_addr,
	// Processor condition
	input  wire logic                           cpu_reset,
	input  wire logic                           cpu_halted,
	input  wire logic                           cpu_disabled,
	input  wire logic                           cpu_clock_ok,
	input  wire logic                           bus_granted,
	input  wire logic                           monitor_entered,
	// Triggers
	input  wire logic                           coax_trigger_pin,
	input  wire logic                           coordination_bus_trigger,
	input  wire logic                           coordination_bus_ready,
	input  wire logic                           coordination_bus_execute,
	input  wire logic                           analyzer_trigger_line_one,
	input  wire logic                           analyzer_trigger_line_two,
	// Breakpoint table upkeep
	input  wire logic                           bp_wr_en,
	input  wire logic [ebc_pkg::EBC_BP_IDX_W-1:0] bp_wr_idx,
	input  wire logic [ebc_pkg::EBC_ADDR_W-1:0] bp_wr_addr,
	input  wire logic                           bp_wr_valid,
	// Requests from the controller
	input  wire logic                           break_request,
	input  wire logic                           temp_break_request,
	input  wire logic                           reg_op_request,
	input  wire logic                           reg_op_write,
	input  wire logic                           reg_read_only,
	input  wire logic                           cause_clear,
	// Results
	output logic                                break_to_monitor,
	output logic                                in_monitor,
	output logic                                run_start,
	output logic [ebc_pkg::EBC_ADDR_W-1:0]      run_start_addr,
	output logic [ebc_pkg::EBC_CAUSE_W-1:0]     break_cause,
	output logic [ebc_pkg::EBC_ADDR_W-1:0]      bp_hit_addr,
	output logic                                break_failed,
	output logic                                reg_op_go,
	output logic                                reg_op_done,
	output ebc_pkg::ebc_reg_status_type         reg_op_status
);
	// ----------------------------------------------------------------
	// Input conditioning
	// ----------------------------------------------------------------
	logic coax_lvl, coax_prev_q, coax_rise;
	logic bp_listed;

	ebc_sync u_coax_sync (
		.clock     (clock),
		.rst_n     (rst_n),
		.pin_in    (coax_trigger_pin),
		.level_out (coax_lvl)
	);

	ebc_bp_table u_bp_table (
		.clock     (clock),
		.rst_n     (rst_n),
		.wr_en     (bp_wr_en),
		.wr_idx    (bp_wr_idx),
		.wr_addr   (bp_wr_addr),
		.wr_valid  (bp_wr_valid),
		.look_addr (acc_addr),
		.hit       (bp_listed)
	);

	// Coordination lines come from logic on this clock, so no synchroniser
	logic cbt_prev_q, rdy_prev_q, exe_prev_q;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			coax_prev_q <= 1'b0;
			cbt_prev_q  <= 1'b0;
			rdy_prev_q  <= 1'b1;
			exe_prev_q  <= 1'b0;
		end else begin
			coax_prev_q <= coax_lvl;
			cbt_prev_q  <= coordination_bus_trigger;
			rdy_prev_q  <= coordination_bus_ready;
			exe_prev_q  <= coordination_bus_execute;
		end
	end
	assign coax_rise = coax_lvl && !coax_prev_q;

	// ----------------------------------------------------------------
	// Break condition detection
	// ----------------------------------------------------------------
	typedef enum {EBC_RUN, EBC_PEND, EBC_MON} ebc_state_type;
	ebc_state_type state_q;
	logic          running;
	logic [ebc_pkg::EBC_CAUSE_W-1:0] cause_now;
	logic blocked, cpu_unable, temp_refused, want_break;

	assign running = (state_q == EBC_RUN);

	always_comb begin
		cause_now = '0;
		cause_now[ebc_pkg::EBC_C_ROM] = running && acc_valid && acc_write && en_rom_break &&
			(acc_region == ebc_pkg::EBC_REG_EROM || acc_region == ebc_pkg::EBC_REG_TROM);
		cause_now[ebc_pkg::EBC_C_GUARD] = running && acc_valid &&
			(acc_region == ebc_pkg::EBC_REG_GUARD);
		cause_now[ebc_pkg::EBC_C_SWBP]  = running && bp_exec && en_soft_bp && bp_listed;
		cause_now[ebc_pkg::EBC_C_UNEXP] = running && bp_exec && en_soft_bp && !bp_listed;
		cause_now[ebc_pkg::EBC_C_COAX]  = running && en_coax_trig && coax_rise;
		cause_now[ebc_pkg::EBC_C_CBTRIG] = running && en_cb_trig &&
			coordination_bus_trigger && !cbt_prev_q;
		cause_now[ebc_pkg::EBC_C_ANALYZER_TRIGGER_LINE_ONE] = running && en_trig_one && analyzer_trigger_line_one;
		cause_now[ebc_pkg::EBC_C_ANALYZER_TRIGGER_LINE_TWO] = running && en_trig_two && analyzer_trigger_line_two;
		cause_now[ebc_pkg::EBC_C_NOTREADY] = running && coord_enable &&
			!coordination_bus_ready && rdy_prev_q;
		cause_now[ebc_pkg::EBC_C_EXECUTE] = coord_enable && coordination_bus_execute && !exe_prev_q;
		cause_now[ebc_pkg::EBC_C_REQUEST] = running && break_request;
	end

	// Temporary service breaks would upset real-time runs, so they are refused outright
	assign temp_refused = running && restrict_real_time && (temp_break_request || reg_op_request);
	assign want_break   = (|cause_now) || (running && !restrict_real_time &&
		(temp_break_request || reg_op_request));
	assign cpu_unable   = cpu_reset || cpu_halted || cpu_disabled || !cpu_clock_ok;
	assign blocked      = cpu_unable || bus_granted;

	// ----------------------------------------------------------------
	// Run / monitor state
	// ----------------------------------------------------------------
	logic exec_pending_q;

	always_ff @(posedge clock) begin
		if (!rst_n)
			state_q <= EBC_RUN;
		else begin
			case (state_q)
				EBC_RUN: if (want_break) state_q <= EBC_PEND;
				EBC_PEND: begin
					if (!blocked && monitor_entered)
						state_q <= EBC_MON;
				end
				EBC_MON: if (exec_pending_q) state_q <= EBC_RUN;
				default: state_q <= EBC_RUN;
			endcase
		end
	end

	// Execute pulse arriving in monitor also counts as the break; run follows it
	always_ff @(posedge clock) begin
		if (!rst_n)
			exec_pending_q <= 1'b0;
		else if (cause_now[ebc_pkg::EBC_C_EXECUTE])
			exec_pending_q <= 1'b1;
		else if (state_q == EBC_MON)
			exec_pending_q <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			run_start      <= 1'b0;
			run_start_addr <= ebc_pkg::EBC_ADDR_RESET;
		end else begin
			run_start <= (state_q == EBC_MON) && exec_pending_q;
			if ((state_q == EBC_MON) && exec_pending_q)
				run_start_addr <= run_address;
		end
	end

	assign break_to_monitor = (state_q == EBC_PEND) && !blocked;
	assign in_monitor       = (state_q == EBC_MON);

	// ----------------------------------------------------------------
	// Cause status and breakpoint address
	// ----------------------------------------------------------------
	// A new cause wins over a clear in the same cycle
	always_ff @(posedge clock) begin
		if (!rst_n)
			break_cause <= ebc_pkg::EBC_CAUSE_RESET;
		else
			break_cause <= (cause_clear ? '0 : break_cause) | cause_now;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			bp_hit_addr <= ebc_pkg::EBC_ADDR_RESET;
		else if (cause_now[ebc_pkg::EBC_C_SWBP] || cause_now[ebc_pkg::EBC_C_UNEXP])
			bp_hit_addr <= acc_addr;
	end

	// Break failure stays set while a pending break is blocked and clears when the block lifts; a refused temporary request sets it while it lasts
	always_ff @(posedge clock) begin
		if (!rst_n)
			break_failed <= 1'b0;
		else
			break_failed <= ((state_q == EBC_PEND) && blocked) || temp_refused;
	end

	// ----------------------------------------------------------------
	// Register operations
	// ----------------------------------------------------------------
	assign reg_op_go = reg_op_request && in_monitor && !(reg_op_write && reg_read_only);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_op_done   <= 1'b0;
			reg_op_status <= ebc_pkg::EBC_RS_OK;
		end else begin
			reg_op_done <= reg_op_request && (in_monitor || temp_refused ||
				((state_q == EBC_PEND) && blocked));
			if (reg_op_request && reg_op_write && reg_read_only && in_monitor)
				reg_op_status <= ebc_pkg::EBC_RS_READONLY;
			else if (reg_op_request && in_monitor)
				reg_op_status <= ebc_pkg::EBC_RS_OK;
			else if (reg_op_request && (temp_refused || (state_q == EBC_PEND && blocked)))
				reg_op_status <= ebc_pkg::EBC_RS_NOBREAK;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	rom_break_a: assert property (@(posedge clock) disable iff (!rst_n)
		running && acc_valid && acc_write && en_rom_break && acc_region == ebc_pkg::EBC_REG_TROM
		|=> state_q == EBC_PEND && break_cause[ebc_pkg::EBC_C_ROM])
		else $error("rom write did not break");
	guard_break_a: assert property (@(posedge clock) disable iff (!rst_n)
		running && acc_valid && acc_region == ebc_pkg::EBC_REG_GUARD |=> break_cause[ebc_pkg::EBC_C_GUARD])
		else $error("guarded access not reported");
	bp_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
		cause_now[ebc_pkg::EBC_C_SWBP] |=> bp_hit_addr == $past(acc_addr))
		else $error("breakpoint address not captured");
	bp_unexp_a: assert property (@(posedge clock) disable iff (!rst_n)
		running && bp_exec && en_soft_bp && !bp_listed |=> break_cause[ebc_pkg::EBC_C_UNEXP])
		else $error("unlisted breakpoint not flagged");
	no_break_blocked_a: assert property (@(posedge clock) disable iff (!rst_n)
		state_q == EBC_PEND && cpu_unable |=> state_q != EBC_MON && break_failed)
		else $error("break completed while unable");
	grant_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		bus_granted |-> !break_to_monitor)
		else $error("break while bus granted");
	real_time_a: assert property (@(posedge clock) disable iff (!rst_n)
		running && restrict_real_time && temp_break_request && !(|cause_now) |=> state_q == EBC_RUN)
		else $error("temporary break taken under real time");
	reg_ro_a: assert property (@(posedge clock) disable iff (!rst_n)
		reg_op_request && reg_op_write && reg_read_only && in_monitor |=> reg_op_status == ebc_pkg::EBC_RS_READONLY)
		else $error("read only register write not reported");
	exec_run_a: assert property (@(posedge clock) disable iff (!rst_n)
		run_start |-> $past(state_q) == EBC_MON)
		else $error("run started without break");

	mon_entry_c: cover property (@(posedge clock) disable iff (!rst_n) state_q == EBC_PEND ##1 state_q == EBC_MON);
	multi_cause_c: cover property (@(posedge clock) disable iff (!rst_n) $countones(cause_now) > 1);
	exec_c: cover property (@(posedge clock) disable iff (!rst_n) run_start);
	fail_c: cover property (@(posedge clock) disable iff (!rst_n) break_failed);
endmodule : ebc_break_ctrl
`default_nettype wire

// File: sim/ebc_cpu_model.sv
// Emulation processor stand-in that acknowledges monitor entry
`timescale 1ns/10ps
`default_nettype none
module ebc_cpu_model (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Break offer and answer
	input  wire logic       break_to_monitor,
	input  wire logic [1:0] delay,
	output logic            monitor_entered
);
	int unsigned wait_q;

	// Enters only an offered break, so a blocked break is never taken
	always_ff @(posedge clock) begin
		if (!rst_n || !break_to_monitor) begin
			wait_q          <= 0;
			monitor_entered <= 1'b0;
		end else begin
			wait_q          <= wait_q + 1;
			monitor_entered <= (wait_q == 32'(delay));
		end
	end
endmodule : ebc_cpu_model
`default_nettype wire

// File: sim/emulator_break_control_test.sv
// Self-checking bench of the break condition control
`timescale 1ns/10ps
`default_nettype none
module emulator_break_control_test;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clock, rst_n, en_rom_break, en_soft_bp, en_coax_trig, en_cb_trig, en_trig_one, en_trig_two;
	logic coord_enable, restrict_real_time, acc_valid, acc_write, bp_exec, monitor_entered;
	logic [ebc_pkg::EBC_ADDR_W-1:0] run_address, acc_addr, bp_wr_addr, run_start_addr, bp_hit_addr, addr_v;
	ebc_pkg::ebc_region_type acc_region;
	logic cpu_reset, cpu_halted, cpu_disabled, cpu_clock_ok, bus_granted, bp_wr_en, bp_wr_valid;
	logic coax_trigger_pin, coordination_bus_trigger, coordination_bus_ready, coordination_bus_execute;
	logic analyzer_trigger_line_one, analyzer_trigger_line_two;
	logic [ebc_pkg::EBC_BP_IDX_W-1:0] bp_wr_idx;
	logic break_request, temp_break_request, reg_op_request, reg_op_write, reg_read_only, cause_clear;
	logic break_to_monitor, in_monitor, run_start, break_failed, reg_op_go, reg_op_done;
	logic [ebc_pkg::EBC_CAUSE_W-1:0] break_cause;
	ebc_pkg::ebc_reg_status_type reg_op_status;
	logic [1:0] delay;
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h3A0CBF68;

	ebc_break_ctrl ebc_break_ctrl_inst (.clock, .rst_n, .en_rom_break, .en_soft_bp, .en_coax_trig, .en_cb_trig,
		.en_trig_one, .en_trig_two, .coord_enable, .restrict_real_time, .run_address, .acc_valid, .acc_write,
		.acc_region, .bp_exec, .acc_addr, .cpu_reset, .cpu_halted, .cpu_disabled, .cpu_clock_ok, .bus_granted,
		.monitor_entered, .coax_trigger_pin, .coordination_bus_trigger, .coordination_bus_ready,
		.coordination_bus_execute, .analyzer_trigger_line_one, .analyzer_trigger_line_two, .bp_wr_en, .bp_wr_idx,
		.bp_wr_addr, .bp_wr_valid, .break_request, .temp_break_request, .reg_op_request, .reg_op_write,
		.reg_read_only, .cause_clear, .break_to_monitor, .in_monitor, .run_start, .run_start_addr, .break_cause,
		.bp_hit_addr, .break_failed, .reg_op_go, .reg_op_done, .reg_op_status);

	ebc_cpu_model ebc_cpu_model_inst (.clock, .rst_n, .break_to_monitor, .delay, .monitor_entered);

	// ----------------------------------------------------------------
	// Helpers and model
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Condition k raises cause bit k; 10 is a write to writable memory, 11 a plain break request
	function automatic int exp_of(input int k, input bit en);
		if (k == 11) return 1 << ebc_pkg::EBC_C_REQUEST;
		if (k == 10) return 0;
		if (k == 1 || en) return 1 << k;
		return 0;
	endfunction : exp_of

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task automatic pulses_off();
		{acc_valid, acc_write, bp_exec, bp_wr_en, bp_wr_valid, cause_clear} = '0;
		{coordination_bus_trigger, coordination_bus_execute, analyzer_trigger_line_one} = '0;
		{analyzer_trigger_line_two, break_request, temp_break_request} = '0;
		acc_region = ebc_pkg::EBC_REG_NONE;
	endtask : pulses_off

	task automatic set_en(input bit e);
		{en_rom_break, en_soft_bp, en_coax_trig, en_cb_trig, en_trig_one, en_trig_two, coord_enable} = {7{e}};
	endtask : set_en

	// The coax pin and ready line return to rest only here
	task automatic do_reset(input int n);
		@(negedge clock);
		rst_n = 1'b0;
		pulses_off();
		{cpu_reset, cpu_halted, cpu_disabled, bus_granted, coax_trigger_pin} = '0;
		{reg_op_request, reg_op_write, reg_read_only, restrict_real_time} = '0;
		{cpu_clock_ok, coordination_bus_ready} = 2'h3;
		delay = 2'(rnd());
		run_address = 20'(rnd());
		repeat (n) @(negedge clock);
		rst_n = 1'b1;
	endtask : do_reset

	task automatic drive(input int k);
		logic [31:0] r;
		r = rnd();
		acc_addr = (k == 3) ? addr_v ^ 20'h00001 : addr_v;
		case (k)
			0, 10: begin
				acc_valid  = 1'b1;
				acc_write  = 1'b1;
				acc_region = (k == 10) ? ebc_pkg::EBC_REG_ERAM :
					(r[0] ? ebc_pkg::EBC_REG_EROM : ebc_pkg::EBC_REG_TROM);
			end
			1: begin
				acc_valid  = 1'b1;
				acc_write  = r[1];
				acc_region = ebc_pkg::EBC_REG_GUARD;
			end
			2, 3: bp_exec = 1'b1;
			4: coax_trigger_pin = 1'b1;
			5: coordination_bus_trigger = 1'b1;
			6: analyzer_trigger_line_one = 1'b1;
			7: analyzer_trigger_line_two = 1'b1;
			8: coordination_bus_ready = 1'b0;
			9: coordination_bus_execute = 1'b1;
			default: break_request = 1'b1;
		endcase
	endtask : drive

	task automatic run_cond(input int k, input bit en);
		int e;
		e = exp_of(k, en);
		do_reset(3);
		set_en(en);
		addr_v = 20'(rnd());
		{bp_wr_en, bp_wr_valid, bp_wr_idx, bp_wr_addr} = {2'h3, 3'h7, addr_v};
		@(negedge clock);
		pulses_off();
		drive(k);
		@(negedge clock);
		pulses_off();
		for (int i = 0; i < 8 && break_cause === '0; i++) @(negedge clock);
		chk(break_cause, e);
		chk(break_to_monitor | in_monitor, e != 0);
		if (k == 2 && en) chk(bp_hit_addr, addr_v);
		if (k == 9 && en) begin
			for (int i = 0; i < 12 && run_start !== 1'b1; i++) @(negedge clock);
			chk(run_start, 1'b1);
			chk(run_start_addr, run_address);
		end
	endtask : run_cond

	// ----------------------------------------------------------------
	// Clock, timeout and sequence
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// The whole run needs fewer than four hundred cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			complete_run();
		end
	end

	initial begin
		rst_n = 1'b0;
		addr_v = '0;
		{acc_addr, bp_wr_addr, bp_wr_idx} = '0;
		set_en(1'b0);
		do_reset(12);
		for (int k = 0; k < 12; k++) begin
			run_cond(k, 1'b1);
			run_cond(k, 1'b0);
		end
		for (int b = 0; b < 5; b++) begin
			do_reset(3);
			{cpu_reset, cpu_halted, cpu_disabled, cpu_clock_ok, bus_granted} = {b == 0, b == 1, b == 2, b != 3, b == 4};
			drive(11);
			@(negedge clock);
			pulses_off();
			repeat (2) @(negedge clock);
			chk(break_to_monitor, 1'b0);
			chk(break_failed, 1'b1);
			{cpu_reset, cpu_halted, cpu_disabled, cpu_clock_ok, bus_granted} = 5'h02;
			for (int i = 0; i < 8 && in_monitor !== 1'b1; i++) @(negedge clock);
			chk(in_monitor, 1'b1);
			chk(break_failed, 1'b0);
		end
		{reg_op_request, reg_op_write, reg_read_only} = 3'h7;
		@(negedge clock);
		chk(reg_op_done, 1'b1);
		chk(reg_op_status, ebc_pkg::EBC_RS_READONLY);
		reg_op_request = 1'b0;
		@(negedge clock);
		{reg_op_request, reg_read_only} = 2'h2;
		#1 chk(reg_op_go, 1'b1);
		@(negedge clock);
		chk(reg_op_status, ebc_pkg::EBC_RS_OK);
		{reg_op_request, cause_clear} = 2'h1;
		@(negedge clock);
		cause_clear = 1'b0;
		chk(break_cause, 11'h000);
		do_reset(3);
		{restrict_real_time, temp_break_request} = 2'h3;
		@(negedge clock);
		temp_break_request = 1'b0;
		chk(break_failed, 1'b1);
		chk(reg_op_status, ebc_pkg::EBC_RS_OK);
		reg_op_request = 1'b1;
		@(negedge clock);
		reg_op_request = 1'b0;
		chk(reg_op_done, 1'b1);
		chk(reg_op_status, ebc_pkg::EBC_RS_NOBREAK);
		do_reset(3);
		set_en(1'b1);
		{bp_wr_en, bp_wr_valid, bp_wr_idx, bp_wr_addr} = {2'h3, 3'h0, addr_v};
		@(negedge clock);
		pulses_off();
		drive(1);
		{bp_exec, analyzer_trigger_line_one} = 2'h3;
		@(negedge clock);
		pulses_off();
		chk(break_cause, 11'h046);
		complete_run();
	end
endmodule : emulator_break_control_test
`default_nettype wire
